// [rtl/can_filter_pkg.sv]
// Constants, field layout and types of the standard-identifier acceptance filter.
// Assumes one 40 MHz clock and an AHB-Lite register port.
// Summary of operation
// - Enabled standard elements are tried in order from element 0 on each standard frame; disabled ones are skipped.
// - The walk ends at the first enabled match or at the last element of the list.
// - Codes 4, 5 and 6 set the high-priority flag, which raises the interrupt if unmasked.
// - A priority match also loads the high-priority status register with its details.
// - Code 0 disables, 1 stores in FIFO 0, 2 stores in FIFO 1, 3 rejects the identifier.
// - Code 4 only flags priority, 5 adds FIFO 0 storage, 6 adds FIFO 1 storage.
// - Code 7 stores to a dedicated buffer or as a debug message and ignores the filter type.
// - The first identifier sits in element bits 26:16.
// - Code 7 needs an exact match on the first identifier with no masking.
// - For codes 1 to 6, element bits 10:0 hold the second identifier.
// - For code 7, second-identifier bits 10:9 pick buffer (00) or debug message A, B, C.
// - On a code 7 match each set bit of second-identifier bits 8:6 pulses its event output one cycle.
// - Second-identifier bits 5:0 are added to the buffer start address to place the frame.
// - Up to 64 extended elements, each at the extended list start plus twice its index.
package can_filter_pkg;
    localparam int          ID_W       = 11;
    localparam int          MADDR_W    = 16;
    localparam int          STD_ELEMS  = 64;
    localparam int          EXT_ELEMS  = 64;
    // Register offsets
    localparam logic [11:0] OFS_CFG    = 12'h000;
    localparam logic [11:0] OFS_RXBUF  = 12'h004;
    localparam logic [11:0] OFS_EXTCFG = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;
    localparam logic [11:0] OFS_MASK   = 12'h010;
    localparam logic [11:0] OFS_HIGH_PRIORITY_MSG_STATUS   = 12'h014;
    localparam logic [3:0]  OFS_ELEM   = 4'h1;
    // Element word fields
    localparam int          SFT_LSB    = 30;
    localparam int          CODE_LSB   = 27;
    localparam int          ID1_LSB    = 16;
    localparam int          ID2_LSB    = 0;
    localparam int          DBG_LSB    = 9;
    localparam int          EVT_LSB    = 6;
    localparam int          OFFS_LSB   = 0;
    // Status and mask bits
    localparam int          IRQ_W      = 3;
    localparam int          IRQ_HPM    = 0;
    localparam int          IRQ_MATCH  = 1;
    localparam int          IRQ_MISS   = 2;
    localparam int          HIGH_PRIORITY_MSG_STATUS_DEST  = 8;
    // Reset values
    localparam logic [6:0]  CFG_RST    = 7'h00;
    localparam logic [15:0] ADDR_RST   = 16'h0000;
    localparam logic [2:0]  MASK_RST   = 3'h0;

    typedef enum logic [2:0] {
        CODE_DISABLE  = 3'b000,
        CODE_FIFO0    = 3'b001,
        CODE_FIFO1    = 3'b010,
        CODE_REJECT   = 3'b011,
        CODE_PRIO     = 3'b100,
        CODE_PRIO_F0  = 3'b101,
        CODE_PRIO_F1  = 3'b110,
        CODE_DEDICATE = 3'b111
    } elem_code_t;

    typedef enum logic [1:0] {
        SFT_RANGE = 2'b00,
        SFT_DUAL  = 2'b01,
        SFT_MASK  = 2'b10,
        SFT_OFF   = 2'b11
    } filt_type_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WALK = 1'b1
    } walk_state_t;
endpackage

// [rtl/can_std_id_acceptance_filter.sv]
// Standard-identifier acceptance filter with its AHB-Lite register slave.
// Assumes identifiers arrive from the receive path on hclk, one frame per rx_ready.
`timescale 1ns/1ps
module can_std_id_acceptance_filter #(
    parameter int N_STD = can_filter_pkg::STD_ELEMS
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Received identifier
    input  wire logic        rx_valid,
    input  wire logic [10:0] rx_id,
    input  wire logic        rx_ide,
    output logic             rx_ready,
    // Filter result
    output logic             res_valid,
    output logic             res_accept,
    output logic             res_reject,
    output logic             res_fifo0,
    output logic             res_fifo1,
    output logic             res_dedicated,
    output logic [1:0]       res_debug,
    output logic             res_extended,
    output logic [5:0]       res_index,
    output logic [15:0]      res_buf_addr,
    // Filter event pulses
    output logic [2:0]       filt_event,
    // Extended element addressing
    input  wire logic [5:0]  ext_idx,
    output logic [15:0]      ext_elem_addr,
    // Interrupt
    output logic             irq
);
    // ------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------
    logic [31:0]      elem_mem [N_STD];
    logic             wr_q, wr_d;
    logic [11:0]      wadr_q, wadr_d;
    logic [31:0]      rdata_q, rdata_d;
    logic [6:0]       cfg_q, cfg_d;
    logic [15:0]      rx_buffer_start_addr_q, rx_buffer_start_addr_d;
    logic [15:0]      extended_list_start_addr_q, extended_list_start_addr_d;
    logic [2:0]       status_q, status_d;
    logic [2:0]       mask_q, mask_d;
    logic [9:0]       high_priority_msg_status_q, high_priority_msg_status_d;
    logic [15:0]      extaddr_q, extaddr_d;
    logic [2:0]       irq_set;
    logic [9:0]       high_priority_msg_status_new;
    logic             acc, mapped, rd_clr, elem_wr;
    logic [5:0]       elem_widx;

    assign acc       = hsel && hready && htrans[1];
    assign mapped    = (haddr[31:12] == 20'h00000);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;
    assign irq       = |(status_q & mask_q);
    assign elem_wr   = wr_q && (wadr_q[11:8] == can_filter_pkg::OFS_ELEM);
    assign elem_widx = wadr_q[7:2];

    always_comb begin
        wr_d      = acc && hwrite && mapped;
        wadr_d    = acc ? haddr[11:0] : wadr_q;
        rdata_d   = rdata_q;
        cfg_d     = cfg_q;
        rx_buffer_start_addr_d    = rx_buffer_start_addr_q;
        extended_list_start_addr_d   = extended_list_start_addr_q;
        mask_d    = mask_q;
        rd_clr    = 1'b0;
        if (acc && !hwrite) begin
            rdata_d = 32'h00000000;
            if (mapped) begin
                case (haddr[11:0])
                    can_filter_pkg::OFS_CFG:    rdata_d = {25'h0000000, cfg_q};
                    can_filter_pkg::OFS_RXBUF:  rdata_d = {16'h0000, rx_buffer_start_addr_q};
                    can_filter_pkg::OFS_EXTCFG: rdata_d = {16'h0000, extended_list_start_addr_q};
                    can_filter_pkg::OFS_STATUS: begin
                        rdata_d = {29'h00000000, status_q};
                        rd_clr  = 1'b1;
                    end
                    can_filter_pkg::OFS_MASK:   rdata_d = {29'h00000000, mask_q};
                    can_filter_pkg::OFS_HIGH_PRIORITY_MSG_STATUS:   rdata_d = {22'h000000, high_priority_msg_status_q};
                    default: begin
                        if (haddr[11:8] == can_filter_pkg::OFS_ELEM &&
                            int'(haddr[7:2]) < N_STD) begin
                            rdata_d = elem_mem[haddr[7:2]];
                        end
                    end
                endcase
            end
        end
        if (wr_q) begin
            case (wadr_q)
                can_filter_pkg::OFS_CFG:    cfg_d   = hwdata[6:0];
                can_filter_pkg::OFS_RXBUF:  rx_buffer_start_addr_d  = hwdata[15:0];
                can_filter_pkg::OFS_EXTCFG: extended_list_start_addr_d = hwdata[15:0];
                can_filter_pkg::OFS_MASK:   mask_d  = hwdata[2:0];
                default:                    ;
            endcase
        end
        // New events win over the read clear
        status_d  = (rd_clr ? 3'h0 : status_q) | irq_set;
        high_priority_msg_status_d    = irq_set[can_filter_pkg::IRQ_HPM] ? high_priority_msg_status_new : high_priority_msg_status_q;
        extaddr_d = extended_list_start_addr_q + {9'h000, ext_idx, 1'b0};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q      <= 1'b0;
            wadr_q    <= 12'h000;
            rdata_q   <= 32'h00000000;
            cfg_q     <= can_filter_pkg::CFG_RST;
            rx_buffer_start_addr_q    <= can_filter_pkg::ADDR_RST;
            extended_list_start_addr_q   <= can_filter_pkg::ADDR_RST;
            status_q  <= can_filter_pkg::MASK_RST;
            mask_q    <= can_filter_pkg::MASK_RST;
            high_priority_msg_status_q    <= 10'h000;
            extaddr_q <= can_filter_pkg::ADDR_RST;
        end else begin
            wr_q      <= wr_d;
            wadr_q    <= wadr_d;
            rdata_q   <= rdata_d;
            cfg_q     <= cfg_d;
            rx_buffer_start_addr_q    <= rx_buffer_start_addr_d;
            extended_list_start_addr_q   <= extended_list_start_addr_d;
            status_q  <= status_d;
            mask_q    <= mask_d;
            high_priority_msg_status_q    <= high_priority_msg_status_d;
            extaddr_q <= extaddr_d;
        end
    end

    assign ext_elem_addr = extaddr_q;

    // Element store, no reset
    always_ff @(posedge hclk) begin
        if (elem_wr && int'(elem_widx) < N_STD) begin
            elem_mem[elem_widx] <= hwdata;
        end
    end

    // ------------------------------------------------------------
    // Filter walk
    // ------------------------------------------------------------
    can_filter_pkg::walk_state_t st_q, st_d;
    can_filter_pkg::elem_code_t  code;
    logic [5:0]       idx_q, idx_d;
    logic [10:0]      id_q, id_d;
    logic [6:0]       lst;
    logic             hit;
    logic [31:0]      cur;
    logic [10:0]      id2;
    logic             v_q, v_d, acc_q, acc_d, rej_q, rej_d, f0_q, f0_d, f1_q, f1_d;
    logic             ded_q, ded_d, ext_q, ext_d;
    logic [1:0]       dbg_q, dbg_d;
    logic [5:0]       ri_q, ri_d;
    logic [15:0]      ba_q, ba_d;
    logic [2:0]       ev_q, ev_d;

    assign cur = elem_mem[idx_q];
    assign id2 = cur[can_filter_pkg::ID2_LSB +: can_filter_pkg::ID_W];
    assign lst = (int'(cfg_q) > N_STD) ? 7'(N_STD) : cfg_q;

    std_filter_match u_match (
        .elem (cur),
        .id   (id_q),
        .hit  (hit),
        .code (code)
    );

    always_comb begin
        st_d     = st_q;
        idx_d    = idx_q;
        id_d     = id_q;
        v_d      = 1'b0;
        ev_d     = 3'h0;
        acc_d    = acc_q;
        rej_d    = rej_q;
        f0_d     = f0_q;
        f1_d     = f1_q;
        ded_d    = ded_q;
        dbg_d    = dbg_q;
        ext_d    = ext_q;
        ri_d     = ri_q;
        ba_d     = ba_q;
        irq_set  = 3'h0;
        high_priority_msg_status_new = {2'b00, 2'b00, idx_q};
        case (st_q)
            can_filter_pkg::ST_IDLE: begin
                if (rx_valid) begin
                    {acc_d, rej_d, f0_d, f1_d, ded_d, dbg_d} = 7'h00;
                    ri_d  = 6'h00;
                    ba_d  = 16'h0000;
                    ext_d = rx_ide;
                    if (rx_ide) begin
                        v_d = 1'b1;
                    end else if (lst == 7'h00) begin
                        v_d = 1'b1;
                        irq_set[can_filter_pkg::IRQ_MISS] = 1'b1;
                    end else begin
                        id_d  = rx_id;
                        idx_d = 6'h00;
                        st_d  = can_filter_pkg::ST_WALK;
                    end
                end
            end
            can_filter_pkg::ST_WALK: begin
                if (hit) begin
                    // first enabled match ends the walk
                    st_d = can_filter_pkg::ST_IDLE;
                    v_d  = 1'b1;
                    ri_d = idx_q;
                    irq_set[can_filter_pkg::IRQ_MATCH] = (code != can_filter_pkg::CODE_REJECT);
                    case (code)
                        can_filter_pkg::CODE_FIFO0:  {acc_d, f0_d} = 2'b11;
                        can_filter_pkg::CODE_FIFO1:  {acc_d, f1_d} = 2'b11;
                        can_filter_pkg::CODE_REJECT: rej_d = 1'b1;
                        can_filter_pkg::CODE_PRIO_F0: {acc_d, f0_d} = 2'b11;
                        can_filter_pkg::CODE_PRIO_F1: {acc_d, f1_d} = 2'b11;
                        can_filter_pkg::CODE_DEDICATE: begin
                            acc_d = 1'b1;
                            dbg_d = id2[can_filter_pkg::DBG_LSB +: 2];
                            ded_d = (id2[can_filter_pkg::DBG_LSB +: 2] == 2'b00);
                            ba_d  = rx_buffer_start_addr_q + {10'h000, id2[can_filter_pkg::OFFS_LSB +: 6]};
                            ev_d  = id2[can_filter_pkg::EVT_LSB +: 3];
                        end
                        default: ;
                    endcase
                    if (code == can_filter_pkg::CODE_PRIO ||
                        code == can_filter_pkg::CODE_PRIO_F0 ||
                        code == can_filter_pkg::CODE_PRIO_F1) begin
                        irq_set[can_filter_pkg::IRQ_HPM] = 1'b1;
                        high_priority_msg_status_new = {code == can_filter_pkg::CODE_PRIO_F1,
                                    code == can_filter_pkg::CODE_PRIO_F0, 2'b00, idx_q};
                    end
                end else if ({1'b0, idx_q} == lst - 7'h01) begin
                    st_d = can_filter_pkg::ST_IDLE;
                    v_d  = 1'b1;
                    irq_set[can_filter_pkg::IRQ_MISS] = 1'b1;
                end else begin
                    idx_d = idx_q + 6'h01;
                end
            end
            default: st_d = can_filter_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q  <= can_filter_pkg::ST_IDLE;
            idx_q <= 6'h00;
            id_q  <= 11'h000;
            v_q   <= 1'b0;
            acc_q <= 1'b0;
            rej_q <= 1'b0;
            f0_q  <= 1'b0;
            f1_q  <= 1'b0;
            ded_q <= 1'b0;
            dbg_q <= 2'b00;
            ext_q <= 1'b0;
            ri_q  <= 6'h00;
            ba_q  <= 16'h0000;
            ev_q  <= 3'h0;
        end else begin
            st_q  <= st_d;
            idx_q <= idx_d;
            id_q  <= id_d;
            v_q   <= v_d;
            acc_q <= acc_d;
            rej_q <= rej_d;
            f0_q  <= f0_d;
            f1_q  <= f1_d;
            ded_q <= ded_d;
            dbg_q <= dbg_d;
            ext_q <= ext_d;
            ri_q  <= ri_d;
            ba_q  <= ba_d;
            ev_q  <= ev_d;
        end
    end

    assign rx_ready      = (st_q == can_filter_pkg::ST_IDLE);
    assign res_valid     = v_q;
    assign res_accept    = acc_q;
    assign res_reject    = rej_q;
    assign res_fifo0     = f0_q;
    assign res_fifo1     = f1_q;
    assign res_dedicated = ded_q;
    assign res_debug     = dbg_q;
    assign res_extended  = ext_q;
    assign res_index     = ri_q;
    assign res_buf_addr  = ba_q;
    assign filt_event    = ev_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_walk_bound;
        @(posedge hclk) disable iff (!hresetn)
        (rx_valid && rx_ready && !rx_ide) |-> ##[1:65] res_valid;
    endproperty
    a_walk_bound: assert property (p_walk_bound) else $error("walk not ended");

    property p_hpm_flag;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == can_filter_pkg::ST_WALK && hit && code[2] && code != 3'b111)
            |=> status_q[can_filter_pkg::IRQ_HPM];
    endproperty
    a_hpm_flag: assert property (p_hpm_flag) else $error("priority flag missing");

    property p_high_priority_msg_status_idx;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == can_filter_pkg::ST_WALK && hit && code == can_filter_pkg::CODE_PRIO)
            |=> high_priority_msg_status_q[5:0] == $past(idx_q);
    endproperty
    a_high_priority_msg_status_idx: assert property (p_high_priority_msg_status_idx) else $error("priority status stale");

    property p_reject;
        @(posedge hclk) disable iff (!hresetn)
        res_valid && res_reject |-> !res_accept && !res_fifo0 && !res_fifo1;
    endproperty
    a_reject: assert property (p_reject) else $error("rejected frame stored");

    property p_one_fifo;
        @(posedge hclk) disable iff (!hresetn)
        res_valid |-> !(res_fifo0 && res_fifo1);
    endproperty
    a_one_fifo: assert property (p_one_fifo) else $error("two fifos chosen");

    property p_ded_acc;
        @(posedge hclk) disable iff (!hresetn)
        res_valid && (res_dedicated || res_debug != 2'b00) |-> res_accept;
    endproperty
    a_ded_acc: assert property (p_ded_acc) else $error("buffer match not accepted");

    property p_event_pulse;
        @(posedge hclk) disable iff (!hresetn)
        (filt_event != 3'h0) |-> res_valid && res_accept ##1 filt_event == 3'h0;
    endproperty
    a_event_pulse: assert property (p_event_pulse) else $error("event pulse wrong");

    property p_ext_addr;
        @(posedge hclk) disable iff (!hresetn)
        $stable(extended_list_start_addr_q) && $stable(ext_idx) |=>
            ext_elem_addr == $past(extended_list_start_addr_q) + {9'h000, $past(ext_idx), 1'b0};
    endproperty
    a_ext_addr: assert property (p_ext_addr) else $error("extended address wrong");

    property p_ext_bypass;
        @(posedge hclk) disable iff (!hresetn)
        (rx_valid && rx_ready && rx_ide) |=> res_valid && res_extended && !res_accept;
    endproperty
    a_ext_bypass: assert property (p_ext_bypass) else $error("extended frame filtered");
endmodule

// [rtl/std_filter_match.sv]
// One standard filter element tried against one identifier.
// Purely combinational; the caller registers the outcome.
`timescale 1ns/1ps
module std_filter_match (
    // Element and identifier
    input  wire logic [31:0]                    elem,
    input  wire logic [can_filter_pkg::ID_W-1:0] id,
    // Outcome
    output logic                                hit,
    output can_filter_pkg::elem_code_t          code
);
    logic [can_filter_pkg::ID_W-1:0] id1;
    logic [can_filter_pkg::ID_W-1:0] id2;
    can_filter_pkg::filt_type_t      std_filter_type;
    logic                            m;

    always_comb begin
        id1  = elem[can_filter_pkg::ID1_LSB +: can_filter_pkg::ID_W];
        id2  = elem[can_filter_pkg::ID2_LSB +: can_filter_pkg::ID_W];
        std_filter_type  = can_filter_pkg::filt_type_t'(elem[can_filter_pkg::SFT_LSB +: 2]);
        code = can_filter_pkg::elem_code_t'(elem[can_filter_pkg::CODE_LSB +: 3]);
        m    = 1'b0;
        if (code == can_filter_pkg::CODE_DEDICATE) begin
            m = (id == id1);
        end else begin
            case (std_filter_type)
                can_filter_pkg::SFT_RANGE: m = (id >= id1) && (id <= id2);
                can_filter_pkg::SFT_DUAL:  m = (id == id1) || (id == id2);
                can_filter_pkg::SFT_MASK:  m = ((id ^ id1) & id2) == '0;
                default:                   m = 1'b0;
            endcase
        end
        hit = m && (code != can_filter_pkg::CODE_DISABLE);
    end
endmodule

// [verification/can_rx_path_model.sv]
// Receive-path model: offers one identifier at a time to the filter.
// Assumes one caller at a time and the filter's hclk.
`timescale 1ns/1ps
module can_rx_path_model (
    // Clock
    input  wire logic   hclk,
    // Identifier handshake
    input  wire logic   rx_ready,
    output logic        rx_valid,
    output logic [10:0] rx_id,
    output logic        rx_ide
);
    initial begin
        rx_valid = 1'b0;
        rx_id    = 11'h000;
        rx_ide   = 1'b0;
    end

    // Holds the offer until taken or 100 cycles pass, then shows inverted lines so stale data never matches
    task automatic offer(input logic [10:0] id, input logic ide, input int gap, output bit ok);
        @(posedge hclk);
        repeat (gap) @(posedge hclk);
        rx_valid <= 1'b1;
        rx_id    <= id;
        rx_ide   <= ide;
        ok = 1'b0;
        for (int i = 0; i < 100 && !ok; i++) begin
            @(posedge hclk);
            ok = (rx_ready === 1'b1);
        end
        rx_valid <= 1'b0;
        rx_id    <= ~id;
        rx_ide   <= ~ide;
    endtask
endmodule

// [verification/tb.sv]
// Self-checking bench for the standard-identifier acceptance filter.
// Assumes a zero-wait AHB-Lite slave and the receive-path model beside it.
`timescale 1ns/1ps
module tb;
    typedef struct {
        logic [31:0] el;
        logic [10:0] id;
        logic [6:0]  exp;
        logic [2:0]  ev;
        logic        pri;
    } row_t;

    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0, res_debug;
    logic [2:0]  hsize = 3'h2, filt_event;
    logic [5:0]  ext_idx = 6'h00, res_index;
    logic [10:0] rx_id;
    logic [15:0] res_buf_addr, ext_elem_addr;
    logic        hreadyout, hresp, rx_valid, rx_ide, rx_ready, res_valid, res_accept, irq;
    logic        res_reject, res_fifo0, res_fifo1, res_dedicated, res_extended;
    logic [31:0] t;
    int          failures = 0, n_checks = 0;
    row_t        rows [10];

    always #12.5 hclk = ~hclk;

    can_std_id_acceptance_filter DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_valid, .rx_id, .rx_ide,
        .rx_ready, .res_valid, .res_accept, .res_reject, .res_fifo0, .res_fifo1, .res_dedicated,
        .res_debug, .res_extended, .res_index, .res_buf_addr, .filt_event, .ext_idx,
        .ext_elem_addr, .irq);
    can_rx_path_model rxp (.hclk, .rx_ready, .rx_valid, .rx_id, .rx_ide);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] el(input logic [1:0] ty, input logic [2:0] c,
                                       input logic [10:0] a, input logic [10:0] b);
        return {ty, c, a, 5'h00, b};
    endfunction

    task automatic final_report;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wait_rdy;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1) begin
            failures++;
            final_report();
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        t = hrdata;
    endtask

    task automatic frame(input logic [10:0] id, input logic ide, input int gap);
        bit ok;
        rxp.offer(id, ide, gap, ok);
        for (int i = 0; i < 80 && res_valid !== 1'b1; i++) @(negedge hclk);
        if (!ok || res_valid !== 1'b1) begin
            failures++;
            final_report();
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rows[0] = '{el(2'h1, 3'h1, 11'h123, 11'h456), 11'h456, 7'h50, 3'h0, 1'b0};
        rows[1] = '{el(2'h0, 3'h2, 11'h100, 11'h1FF), 11'h150, 7'h48, 3'h0, 1'b0};
        rows[2] = '{el(2'h2, 3'h3, 11'h0F0, 11'h7F0), 11'h0F5, 7'h20, 3'h0, 1'b0};
        rows[3] = '{el(2'h1, 3'h4, 11'h0AA, 11'h0BB), 11'h0BB, 7'h00, 3'h0, 1'b1};
        rows[4] = '{el(2'h1, 3'h5, 11'h0AA, 11'h0BB), 11'h0AA, 7'h50, 3'h0, 1'b1};
        rows[5] = '{el(2'h0, 3'h6, 11'h000, 11'h7FF), 11'h7FF, 7'h48, 3'h0, 1'b1};
        rows[6] = '{el(2'h3, 3'h7, 11'h155, 11'h1C5), 11'h155, 7'h44, 3'h7, 1'b0};
        rows[7] = '{el(2'h0, 3'h7, 11'h2AA, 11'h280), 11'h2AA, 7'h41, 3'h2, 1'b0};
        rows[8] = '{el(2'h1, 3'h7, 11'h2AA, 11'h440), 11'h2AA, 7'h42, 3'h1, 1'b0};
        rows[9] = '{el(2'h1, 3'h7, 11'h2AA, 11'h700), 11'h2AA, 7'h43, 3'h4, 1'b0};
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(0, can_filter_pkg::OFS_MASK, 0);
        check(t, 0); // mask reset
        ahb(0, can_filter_pkg::OFS_STATUS, 0);
        check({t[29:0], irq, rx_ready}, 32'h1); // status reset
        ahb(1, can_filter_pkg::OFS_CFG, 1);
        ahb(1, can_filter_pkg::OFS_RXBUF, 32'h200);
        ahb(1, can_filter_pkg::OFS_EXTCFG, 32'h400);
        foreach (rows[k]) begin
            ahb(1, 32'h100, rows[k].el);
            ahb(0, 32'h100, 0);
            check(t, rows[k].el); // element layout
            frame(rows[k].id, 1'b0, k % 3);
            check({res_accept, res_reject, res_fifo0, res_fifo1, res_dedicated, res_debug},
                  rows[k].exp); // result flags
            check({filt_event, res_index}, {rows[k].ev, 6'h00}); // event pulses
            if (rows[k].exp[2]) check(res_buf_addr, 32'h200 + rows[k].el[5:0]); // offset
            ahb(0, can_filter_pkg::OFS_STATUS, 0);
            check(t[0], rows[k].pri); // priority flag
            ahb(0, can_filter_pkg::OFS_HIGH_PRIORITY_MSG_STATUS, 0);
            if (rows[k].pri) check(t & 32'h33F, {rows[k].exp[3], rows[k].exp[4], 8'h00});
        end
        // First enabled match wins; disabled element skipped
        ahb(1, can_filter_pkg::OFS_CFG, 3);
        ahb(1, 32'h100, el(2'h1, 3'h0, 11'h333, 11'h333));
        ahb(1, 32'h104, el(2'h1, 3'h2, 11'h333, 11'h333));
        ahb(1, 32'h108, el(2'h1, 3'h1, 11'h333, 11'h333));
        frame(11'h333, 1'b0, 0);
        check({res_index, res_fifo1}, {6'h01, 1'b1}); // first match
        frame(11'h111, 1'b0, 1);
        ahb(0, can_filter_pkg::OFS_STATUS, 0);
        check({res_accept, t[2]}, 2'b01); // end of list
        frame(11'h333, 1'b1, 0);
        check(res_extended, 1); // extended bypass
        // Interrupt raised, cleared by read, then masked
        ahb(1, can_filter_pkg::OFS_MASK, 1);
        ahb(1, 32'h100, rows[3].el);
        ahb(1, can_filter_pkg::OFS_CFG, 1);
        frame(11'h0BB, 1'b0, 0);
        @(negedge hclk);
        check(irq, 1); // interrupt enabled
        ahb(0, can_filter_pkg::OFS_STATUS, 0);
        @(negedge hclk);
        check({t[0], irq}, 2'b10); // read clears
        ahb(1, can_filter_pkg::OFS_MASK, 0);
        frame(11'h0BB, 1'b0, 2);
        @(negedge hclk);
        check(irq, 0); // masked
        ahb(0, can_filter_pkg::OFS_STATUS, 0);
        check(t[0], 1); // flag set while masked
        ahb(1, 32'h100, el(2'h3, 3'h1, 11'h333, 11'h333));
        frame(11'h333, 1'b0, 0);
        check(res_accept, 0); // type off never matches except with code 7
        @(posedge hclk);
        ext_idx <= 6'h3F;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        check(ext_elem_addr, 32'h47E); // extended address
        // Reset in mid-run clears status and returns to idle
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        ahb(0, can_filter_pkg::OFS_STATUS, 0);
        check({t[29:0], irq, rx_ready}, 32'h1); // status reset
        ahb(1, 32'h800, 32'hFFFFFFFF);
        ahb(0, 32'h800, 0);
        check(t, 0);
        check(hresp, 0);
        final_report();
    end
endmodule
